// file: design/ar_timer_ctrl_pkg.sv
// Constants, register map and state type of the auto-reload timer control block.
// Assumes an APB master with 32-bit data; each 8-bit register sits in one word.
// Function
// - Capture B edge: 0 falling, 1 rising
// - Capture B flag gated by its enable
// - Capture B flag set by first capture only
// - Compare flag sticky, cleared only by software
// - Compare flag gated by its enable
// - Masked zero flag gated by its enable
// - Zero flag only while running (run/reset high), never while held cleared
// - PWM set/reset mode or toggle mode
// - Compare when mask&counter equals mask&compare
// - Zero when mask&counter equals zero
// - Overflow pin polarity in set mode
// - Overflow pin disabled shows polarity level
// - PWM set/reset follows pulse polarity
// - PWM disabled shows polarity level
// - High byte latched, loaded with low byte
// - High byte read returns loaded value
// - Reload/capture writable only when reload enabled
// - Capture register read only, high/low split
// - Compare register read/write, high/low split
// - Mask register read/write, low at E0
// - Interrupt is OR of flag-and-enable pairs and otherIrq
// - Overflow set mode releases on flag clear
package ar_timer_ctrl_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MASK_LO = 8'hE0;
  localparam logic [7:0] IDX_STATUS  = 8'hE2;
  localparam logic [7:0] IDX_OUTCFG  = 8'hE3;
  localparam logic [7:0] IDX_RELOAD_CAPTURE_HIGH_BYTE_HI = 8'hE9;
  localparam logic [7:0] IDX_RELOAD_CAPTURE_HIGH_BYTE_LO = 8'hEA;
  localparam logic [7:0] IDX_CAP_HI  = 8'hEB;
  localparam logic [7:0] IDX_CAP_LO  = 8'hEC;
  localparam logic [7:0] IDX_CMP_HI  = 8'hED;
  localparam logic [7:0] IDX_CMP_LO  = 8'hEE;
  localparam logic [7:0] IDX_MASK_HI = 8'hEF;

  // Status register bit positions
  localparam int ST_CAPB_EDGE = 7;
  localparam int ST_CAPB_IEN  = 6;
  localparam int ST_CAPB_FLG  = 5;
  localparam int ST_CMP_IEN   = 4;
  localparam int ST_CMP_FLG   = 3;
  localparam int ST_ZERO_IEN  = 2;
  localparam int ST_ZERO_FLG  = 1;
  localparam int ST_PWM_MODE  = 0;

  // Flag bits, cleared by a written 0
  localparam logic [7:0] ST_FLAG_MASK = 8'h2A;

  // Output configuration bit positions
  localparam int OC_OVF_POL = 3;
  localparam int OC_OVF_EN  = 2;
  localparam int OC_PWM_POL = 1;
  localparam int OC_PWM_EN  = 0;
  localparam int OC_WIDTH   = 4;

  // Reset values
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [3:0]  OUTCFG_RST = 4'h0;
  localparam logic [15:0] WORD_RST   = 16'h0000;
  localparam logic [7:0]  BYTE_RST   = 8'h00;
  localparam logic [15:0] ZERO_WORD  = 16'h0000;

  // Whole block state, registered as one
  typedef struct packed {
    logic [1:0]  capSync;   // Two-stage synchroniser for capture B pin
    logic        capPrev;   // Previous synchronised level
    logic [7:0]  status;    // Capture/compare/zero status and control
    logic [3:0]  outCfg;    // Output pin configuration
    logic [15:0] reload_capture_high_byte;      // Reload/capture word
    logic [15:0] cap;       // Capture word
    logic [15:0] cmp;       // Compare word
    logic [15:0] mask;      // Mask word
    logic [7:0]  rlcpHi;    // High-byte holding latches
    logic [7:0]  cmpHi;
    logic [7:0]  maskHi;
    logic        pwmLevel;  // PWM pin level
    logic        ovfLevel;  // Overflow pin level
    logic [31:0] rdata;     // Read data for the access phase
    logic        slvErr;    // Error answer for the access phase
  } ctrl_state_t;

endpackage : ar_timer_ctrl_pkg

// file: design/ar_timer_ctrl.sv
// Control part of the 16-bit auto-reload timer: capture B, masked compare
// and masked zero detection, PWM and overflow pins, byte-wise 16-bit registers.
// Assumes the counter core supplies the count, tick, overflow and mode bits
// on the same clock; only the capture B pin is asynchronous.
`timescale 1ns/1ps
module ar_timer_ctrl #(
  parameter int ADDR_W = 12
) (
  // Clock, reset, enable
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // Counter core
  input  wire logic [15:0]         downCounter,
  input  wire logic                countTick,
  input  wire logic                runRes,
  input  wire logic                reloadEnable,
  input  wire logic                rlcpCaptureLoad,
  input  wire logic                overflowEvent,
  input  wire logic                overflowFlag,
  input  wire logic                overflowMode,
  input  wire logic                otherIrq,
  output logic [15:0]              reloadValue,
  output logic                     captureBEvent,
  // Pins
  input  wire logic                captureBInput,
  output logic                     pwmOut,
  output logic                     overflowPin,
  output logic                     timerIrq
);
  import ar_timer_ctrl_pkg::*;

  ctrl_state_t s_reg;   // Registered state
  ctrl_state_t s_next;  // Next state

  // Register index match on a word-aligned byte address
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, idx}) && (a[1:0] == 2'b00);
  endfunction : hit

  // Any mapped register
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, IDX_MASK_LO) || hit(a, IDX_STATUS) || hit(a, IDX_OUTCFG)
          || hit(a, IDX_RELOAD_CAPTURE_HIGH_BYTE_HI) || hit(a, IDX_RELOAD_CAPTURE_HIGH_BYTE_LO) || hit(a, IDX_CAP_HI)
          || hit(a, IDX_CAP_LO) || hit(a, IDX_CMP_HI) || hit(a, IDX_CMP_LO)
          || hit(a, IDX_MASK_HI);
  endfunction : mapped

  // Bus phase decode
  logic setupPhase;   // Setup cycle, read data prepared
  logic writeStrobe;  // Write takes effect at this edge
  logic [7:0] wByte;  // Written byte

  assign setupPhase  = ce && psel && !penable;
  assign writeStrobe = ce && psel && penable && pwrite && !s_reg.slvErr;
  assign wByte       = pwdata[7:0];
  // Zero wait state; answer held off while frozen
  assign pready      = psel && penable && ce;

  // Event detection
  logic capSeen;   // Active edge on capture B
  logic cmpMatch;  // Masked compare condition
  logic zeroMatch; // Masked zero condition
  logic cmpEvent;  // Masked compare event
  logic zeroEvent; // Masked zero event

  // Edge chosen by the edge select bit; reads second stage only
  assign capSeen = s_reg.status[ST_CAPB_EDGE]
                 ? (s_reg.capSync[1] && !s_reg.capPrev)
                 : (!s_reg.capSync[1] && s_reg.capPrev);
  assign cmpMatch  = (s_reg.mask & downCounter) == (s_reg.mask & s_reg.cmp);
  assign zeroMatch = (s_reg.mask & downCounter) == ZERO_WORD;
  // Compare counts once per counter step, so a held value fires only once
  assign cmpEvent  = countTick && cmpMatch;
  // Counter held cleared by run/reset low does not raise zero
  assign zeroEvent = countTick && runRes && zeroMatch;

  // Next-state logic
  always_comb begin
    s_next = s_reg;
    // Synchroniser and edge history
    s_next.capSync = {s_reg.capSync[0], captureBInput};
    s_next.capPrev = s_reg.capSync[1];

    // Register writes
    if (writeStrobe) begin
      if (hit(paddr, IDX_STATUS)) begin
        // Control bits written, flags only cleared by a 0
        s_next.status = (wByte & ~ST_FLAG_MASK)
                      | (s_reg.status & ST_FLAG_MASK & wByte);
      end
      if (hit(paddr, IDX_OUTCFG)) begin
        s_next.outCfg = wByte[OC_WIDTH-1:0];
      end
      // High bytes go to latches only
      if (hit(paddr, IDX_RELOAD_CAPTURE_HIGH_BYTE_HI) && reloadEnable) begin
        s_next.rlcpHi = wByte;
      end
      if (hit(paddr, IDX_CMP_HI)) begin
        s_next.cmpHi = wByte;
      end
      if (hit(paddr, IDX_MASK_HI)) begin
        s_next.maskHi = wByte;
      end
      // Low bytes load the whole word at once
      if (hit(paddr, IDX_RELOAD_CAPTURE_HIGH_BYTE_LO) && reloadEnable) begin
        s_next.reload_capture_high_byte = {s_reg.rlcpHi, wByte};
      end
      if (hit(paddr, IDX_CMP_LO)) begin
        s_next.cmp = {s_reg.cmpHi, wByte};
      end
      if (hit(paddr, IDX_MASK_LO)) begin
        s_next.mask = {s_reg.maskHi, wByte};
      end
    end

    // Capture from counter core into reload/capture word when reload is off
    if (rlcpCaptureLoad && !reloadEnable) begin
      s_next.reload_capture_high_byte = downCounter;
    end

    // Capture B: only an event with the flag clear captures and sets it; compare and zero sets win over clear
    if (capSeen && !s_reg.status[ST_CAPB_FLG]) begin
      s_next.cap = downCounter;
      s_next.status[ST_CAPB_FLG] = 1'b1;
    end
    if (cmpEvent) begin
      s_next.status[ST_CMP_FLG] = 1'b1;
    end
    if (zeroEvent) begin
      s_next.status[ST_ZERO_FLG] = 1'b1;
    end

    // PWM pin
    if (!s_reg.outCfg[OC_PWM_EN]) begin
      // Disabled: idle level is the polarity
      s_next.pwmLevel = s_reg.outCfg[OC_PWM_POL];
    end else if (s_reg.status[ST_PWM_MODE]) begin
      // Toggle mode
      if (cmpEvent) begin
        s_next.pwmLevel = !s_reg.pwmLevel;
      end
    end else begin
      // Set/reset mode; compare wins if both coincide
      if (zeroEvent) begin
        s_next.pwmLevel = !s_reg.outCfg[OC_PWM_POL];
      end
      if (cmpEvent) begin
        s_next.pwmLevel = s_reg.outCfg[OC_PWM_POL];
      end
    end

    // Overflow pin
    if (!s_reg.outCfg[OC_OVF_EN]) begin
      s_next.ovfLevel = s_reg.outCfg[OC_OVF_POL];
    end else if (overflowMode) begin
      if (overflowEvent) begin
        s_next.ovfLevel = !s_reg.ovfLevel;
      end
    end else begin
      // Set mode: active while the overflow flag stands
      if (overflowEvent) begin
        s_next.ovfLevel = !s_reg.outCfg[OC_OVF_POL];
      end else if (!overflowFlag) begin
        s_next.ovfLevel = s_reg.outCfg[OC_OVF_POL];
      end
    end

    // Read data prepared in the setup cycle
    if (setupPhase) begin
      s_next.slvErr = !mapped(paddr);
      s_next.rdata  = 32'h0000_0000;
      if (!pwrite) begin
        if (hit(paddr, IDX_STATUS)) begin
          s_next.rdata[7:0] = s_reg.status;
        end
        if (hit(paddr, IDX_OUTCFG)) begin
          s_next.rdata[OC_WIDTH-1:0] = s_reg.outCfg;
        end
        // High byte reads show the loaded word, never the latch
        if (hit(paddr, IDX_RELOAD_CAPTURE_HIGH_BYTE_HI)) begin
          s_next.rdata[7:0] = s_reg.reload_capture_high_byte[15:8];
        end
        if (hit(paddr, IDX_RELOAD_CAPTURE_HIGH_BYTE_LO)) begin
          s_next.rdata[7:0] = s_reg.reload_capture_high_byte[7:0];
        end
        if (hit(paddr, IDX_CAP_HI)) begin
          s_next.rdata[7:0] = s_reg.cap[15:8];
        end
        if (hit(paddr, IDX_CAP_LO)) begin
          s_next.rdata[7:0] = s_reg.cap[7:0];
        end
        if (hit(paddr, IDX_CMP_HI)) begin
          s_next.rdata[7:0] = s_reg.cmp[15:8];
        end
        if (hit(paddr, IDX_CMP_LO)) begin
          s_next.rdata[7:0] = s_reg.cmp[7:0];
        end
        if (hit(paddr, IDX_MASK_HI)) begin
          s_next.rdata[7:0] = s_reg.mask[15:8];
        end
        if (hit(paddr, IDX_MASK_LO)) begin
          s_next.rdata[7:0] = s_reg.mask[7:0];
        end
      end
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '{capSync: 2'b00, capPrev: 1'b0, status: STATUS_RST,
                 outCfg: OUTCFG_RST, reload_capture_high_byte: WORD_RST, cap: WORD_RST,
                 cmp: WORD_RST, mask: WORD_RST, rlcpHi: BYTE_RST,
                 cmpHi: BYTE_RST, maskHi: BYTE_RST, pwmLevel: 1'b0,
                 ovfLevel: 1'b0, rdata: 32'h0000_0000, slvErr: 1'b0};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign prdata        = s_reg.rdata;
  assign pslverr       = pready && s_reg.slvErr;
  assign reloadValue   = s_reg.reload_capture_high_byte;
  assign captureBEvent = ce && capSeen;
  assign pwmOut        = s_reg.pwmLevel;
  assign overflowPin   = s_reg.ovfLevel;
  // Enabling an already set flag raises the request at once
  assign timerIrq = otherIrq
                  || (s_reg.status[ST_CAPB_FLG] && s_reg.status[ST_CAPB_IEN])
                  || (s_reg.status[ST_CMP_FLG]  && s_reg.status[ST_CMP_IEN])
                  || (s_reg.status[ST_ZERO_FLG] && s_reg.status[ST_ZERO_IEN]);

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_cmp_flag_set: assert property (ce && cmpEvent |=> s_reg.status[ST_CMP_FLG])
    else $error("compare flag not set by compare event");
  a_cmp_flag_sticky: assert property (
    s_reg.status[ST_CMP_FLG] && !(writeStrobe && hit(paddr, IDX_STATUS))
    |=> s_reg.status[ST_CMP_FLG])
    else $error("compare flag dropped without software clear");
  a_zero_gated: assert property (ce && !runRes && !s_reg.status[ST_ZERO_FLG]
    |=> !s_reg.status[ST_ZERO_FLG])
    else $error("zero flag set while counter held in reset");
  a_capb_value: assert property (ce && capSeen && !s_reg.status[ST_CAPB_FLG]
    |=> s_reg.status[ST_CAPB_FLG] && s_reg.cap == $past(downCounter))
    else $error("capture B did not capture counter");
  a_cmp_load: assert property (writeStrobe && hit(paddr, IDX_CMP_LO)
    |=> s_reg.cmp == {$past(s_reg.cmpHi), $past(pwdata[7:0])})
    else $error("compare word not loaded from latch and low byte");
  a_reload_capture_high_byte_locked: assert property (
    writeStrobe && !reloadEnable && !rlcpCaptureLoad |=> $stable(s_reg.reload_capture_high_byte))
    else $error("reload/capture word changed while reload disabled");
  a_hi_read: assert property (setupPhase && !pwrite && hit(paddr, IDX_MASK_HI)
    |=> prdata[7:0] == $past(s_reg.mask[15:8]))
    else $error("mask high read did not return loaded value");
  a_pwm_disabled: assert property (ce && !s_reg.outCfg[OC_PWM_EN]
    |=> pwmOut == $past(s_reg.outCfg[OC_PWM_POL]))
    else $error("disabled PWM pin not at polarity level");
  a_ovf_toggle: assert property (
    ce && s_reg.outCfg[OC_OVF_EN] && overflowMode && overflowEvent
    |=> overflowPin != $past(overflowPin))
    else $error("overflow pin did not toggle");
  a_irq_masked: assert property (
    !otherIrq && !s_reg.status[ST_CAPB_IEN] && !s_reg.status[ST_CMP_IEN]
    && !s_reg.status[ST_ZERO_IEN] |-> !timerIrq)
    else $error("interrupt raised with all enables off");
  a_irq_enable: assert property (
    s_reg.status[ST_CMP_FLG] && s_reg.status[ST_CMP_IEN] |-> timerIrq)
    else $error("enabled compare flag did not raise interrupt");

  // Enabled capture B flag reaches the request
  a_capb_irq: assert property (
    s_reg.status[ST_CAPB_FLG] && s_reg.status[ST_CAPB_IEN] |-> timerIrq)
    else $error("enabled capture B flag did not raise interrupt");
  // Enabled zero flag reaches the request
  a_zero_irq: assert property (
    s_reg.status[ST_ZERO_FLG] && s_reg.status[ST_ZERO_IEN] |-> timerIrq)
    else $error("enabled zero flag did not raise interrupt");
  // Pin level that cannot start the chosen edge leaves the flag clear
  a_capb_edge: assert property (
    ce && !s_reg.status[ST_CAPB_FLG]
    && (s_reg.capSync[1] != s_reg.status[ST_CAPB_EDGE])
    |=> !s_reg.status[ST_CAPB_FLG])
    else $error("capture B flag set by the wrong edge");
  // Later events must not overwrite a pending capture
  a_capb_hold: assert property (
    ce && s_reg.status[ST_CAPB_FLG] |=> $stable(s_reg.cap))
    else $error("capture word changed while flag pending");
  // A written 0 clears the compare flag when no event competes
  a_flag_clear: assert property (
    writeStrobe && hit(paddr, IDX_STATUS) && !pwdata[ST_CMP_FLG] && !cmpEvent
    |=> !s_reg.status[ST_CMP_FLG])
    else $error("compare flag not cleared by written zero");
  // Masked zero while running sets its flag
  a_zero_set: assert property (ce && zeroEvent |=> s_reg.status[ST_ZERO_FLG])
    else $error("zero flag not set by zero event");
  // Toggle mode flips the pin on every compare
  a_pwm_toggle: assert property (
    ce && s_reg.outCfg[OC_PWM_EN] && s_reg.status[ST_PWM_MODE] && cmpEvent
    |=> pwmOut != $past(pwmOut))
    else $error("PWM pin did not toggle on compare");
  // Set/reset mode: compare drives the pin to the polarity level
  a_pwm_cmp_level: assert property (
    ce && s_reg.outCfg[OC_PWM_EN] && !s_reg.status[ST_PWM_MODE] && cmpEvent
    |=> pwmOut == $past(s_reg.outCfg[OC_PWM_POL]))
    else $error("PWM pin wrong after compare in set/reset mode");
  // Set mode: overflow drives the pin away from its idle level
  a_ovf_set: assert property (
    ce && s_reg.outCfg[OC_OVF_EN] && !overflowMode && overflowEvent
    |=> overflowPin != $past(s_reg.outCfg[OC_OVF_POL]))
    else $error("overflow pin not set on overflow");
  // Disabled overflow pin rests at the polarity level
  a_ovf_disabled: assert property (ce && !s_reg.outCfg[OC_OVF_EN]
    |=> overflowPin == $past(s_reg.outCfg[OC_OVF_POL]))
    else $error("disabled overflow pin not at polarity level");
  // Reserved config bits always read as zero
  a_cfg_reserved: assert property (
    setupPhase && !pwrite && hit(paddr, IDX_OUTCFG) |=> prdata[7:OC_WIDTH] == '0)
    else $error("reserved config bits read nonzero");
  // High byte write touches only the latch
  a_hi_latched: assert property (
    writeStrobe && hit(paddr, IDX_MASK_HI) |=> $stable(s_reg.mask))
    else $error("mask word changed by high byte write");

  c_capture_b: cover property (ce && capSeen ##1 s_reg.status[ST_CAPB_FLG]);
  c_pwm_period: cover property (zeroEvent ##[1:1000] cmpEvent);
  c_cmp_write: cover property (writeStrobe && hit(paddr, IDX_CMP_LO));
  c_bad_addr: cover property (pslverr);
  c_ovf_toggle: cover property (ce && overflowMode && overflowEvent);

endmodule : ar_timer_ctrl

// file: tb/capture_pin_model.sv
// Far-side model: drives the capture B pin and loads the PWM output.
// Assumes the bench commands pin edges through setPin on the bench clock.
`timescale 1ns/1ps
module capture_pin_model (
  // Clock
  input  wire logic       clk,
  // Pins
  output logic            captureBInput,
  input  wire logic       pwmOut,
  output logic [7:0]      pwmEdges
);
  logic pwmLast;  // Level seen at the previous edge

  initial begin
    captureBInput = 1'b0;
    pwmLast       = 1'b0;
    pwmEdges      = 8'h00;
  end

  // Pin moves just after a rising edge, like a clean external source
  task automatic setPin(input logic level);
    @(posedge clk);
    captureBInput <= level;
  endtask : setPin

  // Load counts PWM transitions, so toggle mode is seen from outside
  always @(posedge clk) begin
    pwmLast <= pwmOut;
    if (pwmLast !== pwmOut) pwmEdges <= pwmEdges + 8'h01;
  end
endmodule : capture_pin_model

// file: tb/ar_timer_ctrl_bench.sv
// Self-checking bench of the timer control block: APB register access,
// flags, capture B, PWM and overflow pins. Holds ce high except for one frozen compare tick.
`timescale 1ns/1ps
module ar_timer_ctrl_bench;
  import ar_timer_ctrl_pkg::*;
  logic        clk, rst, psel, penable, pwrite, countTick, runRes, reloadEnable;
  logic        overflowEvent, overflowFlag, overflowMode, captureBInput, lvl, capLoad, ce;
  logic        pready, pslverr, captureBEvent, pwmOut, overflowPin, timerIrq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdw;
  logic [15:0] downCounter, reloadValue, val, capVal, zc, cc;
  logic [7:0]  pwmEdges, e0;
  logic [31:0] seed = 32'hE139F30A;  // Fixed seed keeps runs repeatable
  int          err_total = 0;
  int          cmp_count = 0;
  int          capEvents = 0;  // Capture B pulses seen
  // Every mapped register, all zero after reset
  localparam logic [7:0] IDX_LIST [10] = '{IDX_MASK_LO, IDX_STATUS, IDX_OUTCFG,
    IDX_RELOAD_CAPTURE_HIGH_BYTE_HI, IDX_RELOAD_CAPTURE_HIGH_BYTE_LO, IDX_CAP_HI, IDX_CAP_LO, IDX_CMP_HI, IDX_CMP_LO, IDX_MASK_HI};

  // Pseudo-random source
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // Index to byte address, one word per register
  function automatic logic [11:0] byteAddr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : byteAddr

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; extra edge after release avoids a double drive
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= byteAddr(idx);
    pwdata  <= 32'(wd);
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) err_total++;
    rdw = prdata;
    er  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rdw, 32'(exp));
  endtask : rdChk

  // High byte first, then low byte loads the word
  task automatic wr16(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] v);
    apb(1'b1, hi, v[15:8]);
    apb(1'b1, lo, v[7:0]);
  endtask : wr16

  // One counter step with the given count
  task automatic tick(input logic [15:0] cnt);
    downCounter <= cnt;
    countTick   <= 1'b1;
    @(posedge clk);
    countTick <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : tick

  task automatic ovfPulse();
    overflowEvent <= 1'b1;
    @(posedge clk);
    overflowEvent <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : ovfPulse

  // Capture pin edge, then status after the synchroniser settles
  task automatic capEdge(input logic level, input logic [7:0] exp);
    u_capture_pin_model.setPin(level);
    repeat (8) @(posedge clk);
    rdChk(IDX_STATUS, exp);
  endtask : capEdge

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  ar_timer_ctrl #(.ADDR_W(12)) u_ar_timer_ctrl (
    .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .downCounter(downCounter), .countTick(countTick), .runRes(runRes),
    .reloadEnable(reloadEnable), .rlcpCaptureLoad(capLoad), .overflowEvent(overflowEvent),
    .overflowFlag(overflowFlag), .overflowMode(overflowMode), .otherIrq(1'b0),
    .reloadValue(reloadValue), .captureBEvent(captureBEvent),
    .captureBInput(captureBInput), .pwmOut(pwmOut), .overflowPin(overflowPin),
    .timerIrq(timerIrq));

  capture_pin_model u_capture_pin_model (
    .clk(clk), .captureBInput(captureBInput), .pwmOut(pwmOut), .pwmEdges(pwmEdges));

  // Count capture B pulses as the design's flops see them
  always @(posedge clk) begin
    if (captureBEvent === 1'b1) capEvents <= capEvents + 1;
  end

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  // Main sequence
  initial begin
    {rst, psel, penable, pwrite, countTick, runRes, reloadEnable} = 7'h01 << 6;
    {overflowEvent, overflowFlag, overflowMode, capLoad} = 4'h0;
    ce = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    downCounter = 16'h0000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (IDX_LIST[i]) rdChk(IDX_LIST[i], 8'h00);
    apb(1'b0, 8'hE1, 8'h00);
    chk(32'(er), 32'h1);  // Unmapped slot answers with an error
    $display("test reset_map done");
    seed = xorshift(seed);
    val = seed[15:0] | 16'h8001;
    apb(1'b1, IDX_CMP_HI, val[15:8]);
    rdChk(IDX_CMP_HI, 8'h00);
    apb(1'b1, IDX_CMP_LO, val[7:0]);
    rdChk(IDX_CMP_HI, val[15:8]);
    rdChk(IDX_CMP_LO, val[7:0]);
    wr16(IDX_MASK_HI, IDX_MASK_LO, 16'hFF00);
    rdChk(IDX_MASK_HI, 8'hFF);
    seed = xorshift(seed);
    wr16(IDX_RELOAD_CAPTURE_HIGH_BYTE_HI, IDX_RELOAD_CAPTURE_HIGH_BYTE_LO, seed[15:0]);
    rdChk(IDX_RELOAD_CAPTURE_HIGH_BYTE_LO, 8'h00);
    reloadEnable <= 1'b1;
    wr16(IDX_RELOAD_CAPTURE_HIGH_BYTE_HI, IDX_RELOAD_CAPTURE_HIGH_BYTE_LO, seed[15:0]);
    rdChk(IDX_RELOAD_CAPTURE_HIGH_BYTE_HI, seed[15:8]);
    chk(32'(reloadValue), 32'(seed[15:0]));
    reloadEnable <= 1'b0;
    capLoad      <= 1'b1;  // Counter captured while reload is off
    downCounter  <= ~seed[15:0];
    @(posedge clk);
    capLoad <= 1'b0;
    rdChk(IDX_RELOAD_CAPTURE_HIGH_BYTE_LO, ~seed[7:0]);
    $display("test words done");
    zc = {8'h00, seed[23:16]};
    cc = {val[15:8], seed[31:24]};
    tick(cc);
    rdChk(IDX_STATUS, 8'h08);
    tick(zc);
    rdChk(IDX_STATUS, 8'h08);
    apb(1'b1, IDX_STATUS, 8'h18);
    chk(32'(timerIrq), 32'h1);
    apb(1'b1, IDX_STATUS, 8'h08);
    chk(32'(timerIrq), 32'h0);
    apb(1'b1, IDX_STATUS, 8'h00);
    rdChk(IDX_STATUS, 8'h00);
    ce <= 1'b0;  // Frozen: a compare tick must leave no trace
    tick(cc);
    ce <= 1'b1;
    rdChk(IDX_STATUS, 8'h00);
    runRes <= 1'b1;
    tick(zc);
    rdChk(IDX_STATUS, 8'h02);
    apb(1'b1, IDX_STATUS, 8'h06);
    chk(32'(timerIrq), 32'h1);
    apb(1'b1, IDX_STATUS, 8'h04);
    chk(32'(timerIrq), 32'h0);
    $display("test flags done");
    capVal = seed[31:16] ^ seed[15:0];
    downCounter <= capVal;
    apb(1'b1, IDX_STATUS, 8'hC0);
    capEdge(1'b1, 8'hE0);
    chk(32'(timerIrq), 32'h1);
    rdChk(IDX_CAP_HI, capVal[15:8]);
    apb(1'b1, IDX_STATUS, 8'hA0);
    chk(32'(timerIrq), 32'h0);
    apb(1'b1, IDX_STATUS, 8'h80);
    capEdge(1'b0, 8'h80);
    apb(1'b1, IDX_STATUS, 8'h00);
    capEdge(1'b1, 8'h00);
    capEdge(1'b0, 8'h20);
    wr16(IDX_CAP_HI, IDX_CAP_LO, ~capVal);
    rdChk(IDX_CAP_LO, capVal[7:0]);
    chk(32'(capEvents), 32'h2);
    apb(1'b1, IDX_STATUS, 8'h00);
    $display("test capture done");
    apb(1'b1, IDX_OUTCFG, 8'h01);
    tick(zc);
    chk(32'(pwmOut), 32'h1);
    tick(cc);
    chk(32'(pwmOut), 32'h0);
    apb(1'b1, IDX_OUTCFG, 8'h03);
    tick(cc);
    chk(32'(pwmOut), 32'h1);
    tick(zc);
    chk(32'(pwmOut), 32'h0);
    apb(1'b1, IDX_OUTCFG, 8'h02);
    tick(zc);
    chk(32'(pwmOut), 32'h1);
    apb(1'b1, IDX_OUTCFG, 8'h00);
    @(posedge clk);  // Pin follows the new config one edge later
    chk(32'(pwmOut), 32'h0);
    apb(1'b1, IDX_STATUS, 8'h01);
    apb(1'b1, IDX_OUTCFG, 8'h01);
    repeat (2) @(posedge clk);
    e0 = pwmEdges;
    repeat (3) tick(cc);
    tick(zc);
    e0 = pwmEdges - e0;
    chk(32'(e0), 32'h3);
    $display("test pwm done");
    apb(1'b1, IDX_OUTCFG, 8'h04);
    overflowFlag <= 1'b1;
    ovfPulse();
    chk(32'(overflowPin), 32'h1);
    overflowFlag <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(overflowPin), 32'h0);
    apb(1'b1, IDX_OUTCFG, 8'h0C);
    @(posedge clk);  // Pin follows the new config one edge later
    chk(32'(overflowPin), 32'h1);
    overflowFlag <= 1'b1;
    ovfPulse();
    chk(32'(overflowPin), 32'h0);
    overflowFlag <= 1'b0;
    apb(1'b1, IDX_OUTCFG, 8'h08);
    ovfPulse();
    chk(32'(overflowPin), 32'h1);
    overflowMode <= 1'b1;
    apb(1'b1, IDX_OUTCFG, 8'h04);
    repeat (2) begin
      lvl = overflowPin;
      ovfPulse();
      chk(32'(overflowPin), 32'(!lvl));
    end
    apb(1'b1, IDX_OUTCFG, 8'hFF);
    rdChk(IDX_OUTCFG, 8'h0F);
    $display("test outputs done");
    give_verdict();
  end
endmodule : ar_timer_ctrl_bench
